// File: hw/codec_port_pkg.sv
package codec_port_pkg;
   // ****************************************
   // Word and frame geometry
   // ****************************************
   localparam int DATA_W = 16;
   localparam logic [7:0] SEC_SLOT = 8'h80;
   localparam logic [4:0] XFER_BITS = 5'h10;
   localparam logic [4:0] LAST_BIT = 5'h0F;
   localparam logic [4:0] HDR_LAST_BIT = 5'h07;
   localparam logic [4:0] DATA_FIRST_BIT = 5'h08;
   // ****************************************
   // Secondary word fields
   // ****************************************
   localparam int MS_POS = 15;
   localparam int READ_FLAG_POS = 13;
   localparam int HDR_READ_FLAG_POS = 5;
   localparam int HDR_LSB = 8;
   localparam int ADDR_W = 5;
   // ****************************************
   // Register file
   // ****************************************
   localparam int NUM_REGS = 6;
   localparam logic [ADDR_W-1:0] REG_ADDR_MIN = 5'h01;
   localparam logic [ADDR_W-1:0] REG_ADDR_MAX = 5'h06;
   localparam int CTRL1_IDX = 1;
   localparam int MODE16_BIT = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ****************************************
   // Timing
   // ****************************************
   localparam int SYS_PERIOD_NS = 100;
   // Half period of ten clocks leaves room for both pin filters and the host's turn-around
   localparam int SCLK_PERIOD_NS = 2000;
   localparam int SCLK_HALF_INT = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
   localparam int SCLK_DIV_W = 4;
   localparam logic [SCLK_DIV_W-1:0] SCLK_HALF_LAST = SCLK_DIV_W'(SCLK_HALF_INT - 1);
   // ****************************************
   // Frame kinds
   // ****************************************
   typedef enum logic [1:0]
   {
      FRAME_IDLE = 2'b00,
      FRAME_PRI = 2'b01,
      FRAME_SEC = 2'b10
   } frame_t;
endpackage

// File: hw/codec_link_if.sv
`timescale 1ns/10ps
interface codec_link_if;
   logic sclk;
   logic fs_n;
   logic dout;
   logic dout_oe;
   logic din;
   logic fc;
   logic dout_line;

   // Released data line rests high, as on a pull-up
   assign dout_line = dout_oe ? dout : 1'b1;

   modport device
   (
      output sclk,
      output fs_n,
      output dout,
      output dout_oe,
      input din,
      input fc
   );

   modport host
   (
      input sclk,
      input fs_n,
      input dout_line,
      output din,
      output fc
   );
endinterface

// File: hw/codec_port_device.sv
`timescale 1ns/10ps
// Summary of operation
// - Each primary frame carries one 16-bit DAC word.
// - Sample DIN on falling edges, one word/frame.
// - Control register 1 selects 16 or 15+1 format.
// - In 15+1, word LSB requests secondary frame.
// - In 16-bit format host raises request pin.
// - Secondary frame carries 16-bit register command word.
// - All-zero upper byte is no-op, nothing changes.
// - Read flag set: return addressed register same frame.
// - Primary frames shift ADC out and DAC in together.
// - Registers change only via secondary DIN falling-edge bits.
// - Unaddressed registers keep their reset defaults.
// - Read flag set means no register write.
// - Host write word: zeros, flag 0, address, data.
// - Read reply echoes header, indicator, register data.
// - Write reply echoes header, low byte zero.
// - Top secondary output bit is master/slave indicator.
// - Frame sync rises on seventeenth rising clock edge.
// - Request pin captured at primary frame sync rise.
module codec_port_device
   import codec_port_pkg::*;
#(
   parameter logic MASTER_IND = 1'b1
)
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   codec_link_if.device LINK,
   input wire logic [DATA_W-1:0] ADC_WORD,
   output logic [DATA_W-1:0] DAC_WORD,
   output logic DAC_VALID,
   output logic DAC_MODE16
);
   // ****************************************
   // Pin input filters
   // ****************************************
   logic [1:0] pin_raw;
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync3_reg;
   logic [1:0] pin_s_reg;
   wire din_s;
   wire fc_s;

   assign pin_raw = {LINK.fc, LINK.din};
   assign din_s = pin_s_reg[0];
   assign fc_s = pin_s_reg[1];

   for (genvar i = 0; i < 2; i++)
   begin : g_sync
      always_ff @(posedge SYS_CLK)
      begin
         if (!RST_N)
         begin
            sync1_reg[i] <= 1'b0;
            sync2_reg[i] <= 1'b0;
            sync3_reg[i] <= 1'b0;
            pin_s_reg[i] <= 1'b0;
         end
         else
         begin
            sync1_reg[i] <= pin_raw[i];
            sync2_reg[i] <= sync1_reg[i];
            sync3_reg[i] <= sync2_reg[i];
            if (sync2_reg[i] == sync3_reg[i])
            begin
               pin_s_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   // ****************************************
   // Shift clock divider and frame slot count
   // ****************************************
   logic [SCLK_DIV_W-1:0] div_reg;
   logic sclk_reg;
   logic [7:0] slot_reg;

   wire div_done = (div_reg == SCLK_HALF_LAST);
   wire rise_evt = div_done & ~sclk_reg;
   wire fall_evt = div_done & sclk_reg;

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         div_reg <= '0;
         sclk_reg <= 1'b0;
         slot_reg <= 8'h00;
      end
      else
      begin
         div_reg <= div_done ? '0 : div_reg + 1'b1;
         if (div_done)
         begin
            sclk_reg <= ~sclk_reg;
         end
         if (rise_evt)
         begin
            slot_reg <= slot_reg + 8'h01;
         end
      end
   end

   // ****************************************
   // Frame decoding
   // ****************************************
   frame_t frame_reg;
   logic [4:0] bit_reg;
   logic fs_n_reg;
   logic dout_reg;
   logic dout_oe_reg;
   logic [DATA_W-1:0] tx_shift_reg;
   logic [DATA_W-1:0] rx_shift_reg;
   logic [7:0] hdr_reg;
   logic sec_req_reg;
   logic [DATA_W-1:0] dac_word_reg;
   logic dac_valid_reg;
   logic [7:0] regs_reg [1:NUM_REGS];

   wire active = (frame_reg != FRAME_IDLE);
   wire start_pri = rise_evt && (slot_reg == 8'h00);
   wire start_sec = rise_evt && (slot_reg == SEC_SLOT) && sec_req_reg;
   wire end_xfer = rise_evt && active && (bit_reg == XFER_BITS);
   wire shift_in = fall_evt && active && (bit_reg < XFER_BITS);
   wire mode16 = regs_reg[CTRL1_IDX][MODE16_BIT];
   wire [DATA_W-1:0] cmd_word = {rx_shift_reg[DATA_W-2:0], din_s};
   wire [ADDR_W-1:0] cmd_addr = cmd_word[HDR_LSB+ADDR_W-1:HDR_LSB];
   wire cmd_noop = (cmd_word[DATA_W-1:HDR_LSB] == 8'h00);
   wire cmd_addr_ok = (cmd_addr >= REG_ADDR_MIN) && (cmd_addr <= REG_ADDR_MAX);
   wire cmd_write = shift_in && (frame_reg == FRAME_SEC) && (bit_reg == LAST_BIT) && !cmd_noop
      && !cmd_word[READ_FLAG_POS] && cmd_addr_ok;
   wire [ADDR_W-1:0] rd_addr = hdr_reg[ADDR_W-1:0];
   wire rd_addr_ok = (rd_addr >= REG_ADDR_MIN) && (rd_addr <= REG_ADDR_MAX);
   wire [7:0] rd_byte = rd_addr_ok ? regs_reg[rd_addr] : 8'h00;
   wire rd_flag = hdr_reg[HDR_READ_FLAG_POS];
   wire sec_bit = (bit_reg == 5'h00) ? MASTER_IND :
      (bit_reg < DATA_FIRST_BIT) ? din_s :
      (rd_flag ? rd_byte[~bit_reg[2:0]] : 1'b0);
   wire next_dout = (frame_reg == FRAME_SEC) ? sec_bit : tx_shift_reg[DATA_W-1];
   wire req_now = mode16 ? fc_s : rx_shift_reg[0];

   // ****************************************
   // Frame sequencing
   // ****************************************
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         frame_reg <= FRAME_IDLE;
         bit_reg <= 5'h00;
         fs_n_reg <= 1'b1;
         sec_req_reg <= 1'b0;
      end
      else if (start_pri || start_sec)
      begin
         frame_reg <= start_pri ? FRAME_PRI : FRAME_SEC;
         bit_reg <= 5'h00;
         fs_n_reg <= 1'b0;
      end
      else if (end_xfer)
      begin
         frame_reg <= FRAME_IDLE;
         fs_n_reg <= 1'b1;
         sec_req_reg <= (frame_reg == FRAME_PRI) ? req_now : 1'b0;
      end
      else if (shift_in)
      begin
         bit_reg <= bit_reg + 5'h01;
      end
   end

   // ****************************************
   // Data path
   // ****************************************
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         dout_reg <= 1'b0;
         dout_oe_reg <= 1'b0;
         tx_shift_reg <= '0;
         rx_shift_reg <= '0;
         hdr_reg <= 8'h00;
      end
      else if (start_pri || start_sec)
      begin
         tx_shift_reg <= ADC_WORD;
      end
      else if (end_xfer)
      begin
         dout_oe_reg <= 1'b0;
      end
      else if (shift_in)
      begin
         dout_reg <= next_dout;
         dout_oe_reg <= 1'b1;
         tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
         rx_shift_reg <= cmd_word;
         if (bit_reg == HDR_LAST_BIT)
         begin
            hdr_reg <= cmd_word[7:0];
         end
      end
   end

   // ****************************************
   // DAC word hand-off
   // ****************************************
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         dac_word_reg <= '0;
         dac_valid_reg <= 1'b0;
      end
      else
      begin
         dac_valid_reg <= end_xfer && (frame_reg == FRAME_PRI);
         if (end_xfer && (frame_reg == FRAME_PRI))
         begin
            dac_word_reg <= rx_shift_reg;
         end
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   for (genvar r = 1; r <= NUM_REGS; r++)
   begin : g_regs
      always_ff @(posedge SYS_CLK)
      begin
         if (!RST_N)
         begin
            regs_reg[r] <= REG_RESET;
         end
         else if (cmd_write && (cmd_addr == ADDR_W'(r)))
         begin
            regs_reg[r] <= cmd_word[7:0];
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign LINK.sclk = sclk_reg;
   assign LINK.fs_n = fs_n_reg;
   assign LINK.dout = dout_reg;
   assign LINK.dout_oe = dout_oe_reg;
   assign DAC_WORD = dac_word_reg;
   assign DAC_VALID = dac_valid_reg;
   assign DAC_MODE16 = mode16;
endmodule // codec_port_device

// File: hw/codec_port_host.sv
`timescale 1ns/10ps
module codec_port_host
   import codec_port_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   codec_link_if.host LINK,
   input wire logic MODE16,
   input wire logic [DATA_W-1:0] DAC_WORD,
   input wire logic CMD_VALID,
   input wire logic [DATA_W-1:0] CMD_WORD,
   output logic CMD_READY,
   output logic [DATA_W-1:0] ADC_WORD,
   output logic ADC_VALID,
   output logic [DATA_W-1:0] REPLY_WORD,
   output logic REPLY_VALID
);
   // ****************************************
   // Pin input filters
   // ****************************************
   logic [2:0] pin_raw;
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] sync3_reg;
   logic [2:0] pin_s_reg;
   logic sclk_d_reg;
   logic fs_d_reg;
   logic dout_d_reg;

   assign pin_raw = {LINK.dout_line, LINK.fs_n, LINK.sclk};

   for (genvar i = 0; i < 3; i++)
   begin : g_sync
      always_ff @(posedge SYS_CLK)
      begin
         if (!RST_N)
         begin
            sync1_reg[i] <= 1'b1;
            sync2_reg[i] <= 1'b1;
            sync3_reg[i] <= 1'b1;
            pin_s_reg[i] <= 1'b1;
         end
         else
         begin
            sync1_reg[i] <= pin_raw[i];
            sync2_reg[i] <= sync1_reg[i];
            sync3_reg[i] <= sync2_reg[i];
            if (sync2_reg[i] == sync3_reg[i])
            begin
               pin_s_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   // ****************************************
   // Edge detection
   // ****************************************
   wire sclk_rise = pin_s_reg[0] & ~sclk_d_reg;
   wire fs_fall = ~pin_s_reg[1] & fs_d_reg;
   wire fs_high = pin_s_reg[1];

   // ****************************************
   // Frame state
   // ****************************************
   frame_t frame_reg;
   logic [DATA_W-1:0] tx_shift_reg;
   logic [DATA_W-1:0] rx_shift_reg;
   logic din_reg;
   logic fc_reg;
   logic cmd_pend_reg;
   logic [DATA_W-1:0] cmd_word_reg;
   logic req_sent_reg;
   logic sec_due_reg;
   logic cmd_ready_reg;
   logic [DATA_W-1:0] adc_word_reg;
   logic adc_valid_reg;
   logic [DATA_W-1:0] reply_word_reg;
   logic reply_valid_reg;

   wire [DATA_W-1:0] pri_word = MODE16 ? DAC_WORD : {DAC_WORD[DATA_W-1:1], cmd_pend_reg};
   wire [DATA_W-1:0] load_word = sec_due_reg ? cmd_word_reg : pri_word;
   wire [DATA_W-1:0] rx_word = {rx_shift_reg[DATA_W-2:0], dout_d_reg};
   wire shifting = sclk_rise && (frame_reg != FRAME_IDLE);
   wire frame_done = shifting && fs_high;
   wire cmd_take = CMD_VALID && cmd_ready_reg;

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         // Matches the filter's reset level so no false clock rise follows reset
         sclk_d_reg <= 1'b1;
         fs_d_reg <= 1'b1;
         dout_d_reg <= 1'b0;
         frame_reg <= FRAME_IDLE;
         tx_shift_reg <= '0;
         rx_shift_reg <= '0;
         din_reg <= 1'b0;
         fc_reg <= 1'b0;
         cmd_pend_reg <= 1'b0;
         cmd_word_reg <= '0;
         req_sent_reg <= 1'b0;
         sec_due_reg <= 1'b0;
         cmd_ready_reg <= 1'b1;
         adc_word_reg <= '0;
         adc_valid_reg <= 1'b0;
         reply_word_reg <= '0;
         reply_valid_reg <= 1'b0;
      end
      else
      begin
         sclk_d_reg <= pin_s_reg[0];
         fs_d_reg <= pin_s_reg[1];
         // Previous sample keeps the last bit valid after output release
         dout_d_reg <= pin_s_reg[2];
         adc_valid_reg <= 1'b0;
         reply_valid_reg <= 1'b0;
         if (cmd_take)
         begin
            cmd_pend_reg <= 1'b1;
            cmd_word_reg <= CMD_WORD;
            cmd_ready_reg <= 1'b0;
         end
         if (fs_fall)
         begin
            frame_reg <= sec_due_reg ? FRAME_SEC : FRAME_PRI;
            din_reg <= load_word[DATA_W-1];
            tx_shift_reg <= {load_word[DATA_W-2:0], 1'b0};
            if (!sec_due_reg)
            begin
               req_sent_reg <= cmd_pend_reg;
               fc_reg <= MODE16 && cmd_pend_reg;
            end
         end
         else if (frame_done)
         begin
            frame_reg <= FRAME_IDLE;
            fc_reg <= 1'b0;
            if (frame_reg == FRAME_PRI)
            begin
               adc_word_reg <= rx_word;
               adc_valid_reg <= 1'b1;
               sec_due_reg <= req_sent_reg;
            end
            else
            begin
               reply_word_reg <= rx_word;
               reply_valid_reg <= 1'b1;
               sec_due_reg <= 1'b0;
               cmd_pend_reg <= 1'b0;
               cmd_ready_reg <= 1'b1;
            end
         end
         else if (shifting)
         begin
            rx_shift_reg <= rx_word;
            din_reg <= tx_shift_reg[DATA_W-1];
            tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign LINK.din = din_reg;
   assign LINK.fc = fc_reg;
   assign CMD_READY = cmd_ready_reg;
   assign ADC_WORD = adc_word_reg;
   assign ADC_VALID = adc_valid_reg;
   assign REPLY_WORD = reply_word_reg;
   assign REPLY_VALID = reply_valid_reg;
endmodule // codec_port_host

// File: dv/codec_serial_frame_port_asserts.sv
`timescale 1ns/10ps
module codec_serial_frame_port_asserts
#(
   parameter logic MASTER_IND = 1'b1
)
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic sclk,
   input wire logic fs_n,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic din
);
   // *****
   // Frame phase since the first sync
   // *****
   logic fs_q_reg;
   logic sclk_q_reg;
   logic seen_reg;
   logic fell_w;
   logic rise_w;
   logic [7:0] ph_reg;
   logic [7:0] ph_next;
   logic [4:0] lo_cnt_reg;
   logic [4:0] lo_cnt_next;

   assign fell_w = fs_q_reg & ~fs_n;
   assign rise_w = sclk & ~sclk_q_reg;
   // Shift clock rises since the first sync, wrapping once per frame period
   assign ph_next = (fell_w & ~seen_reg) ? 8'h01 : ph_reg + {7'h00, rise_w};
   // Rises strictly between the two bounding rises of a frame
   assign lo_cnt_next = fell_w ? 5'h00 : lo_cnt_reg + {4'h0, rise_w & ~fs_n};

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         fs_q_reg <= 1'b1;
         sclk_q_reg <= 1'b0;
         seen_reg <= 1'b0;
         ph_reg <= 8'h00;
         lo_cnt_reg <= 5'h00;
      end
      else
      begin
         fs_q_reg <= fs_n;
         sclk_q_reg <= sclk;
         seen_reg <= seen_reg | fell_w;
         ph_reg <= ph_next;
         lo_cnt_reg <= lo_cnt_next;
      end
   end

   // *****
   // Link checks
   // *****
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   frame_len_a: assert property ($rose(fs_n) |-> lo_cnt_reg == 5'h0F)
      else $error("frame sync low time wrong");
   fs_fall_a: assert property ($fell(fs_n) |-> $rose(sclk))
      else $error("frame sync fell away from a clock rise");
   fs_rise_a: assert property ($rose(fs_n) |-> $rose(sclk))
      else $error("frame sync rose away from a clock rise");
   slot_a: assert property (fell_w && seen_reg |-> ph_reg == 8'h00 || ph_reg == 8'h80)
      else $error("frame sync outside its slot");
   oe_off_a: assert property (fs_n |-> !dout_oe)
      else $error("data output driven outside a frame");
   oe_on_a: assert property ($fell(fs_n) |-> !dout_oe ##[7:10] dout_oe)
      else $error("data output not enabled in frame");
   dout_hold_a: assert property ($rose(sclk) && !fs_n && dout_oe |-> $stable(dout))
      else $error("data output moved at clock rise");
   din_hold_a: assert property ($fell(sclk) && !fs_n |-> $stable(din))
      else $error("data input moved at clock fall");
   ms_bit_a: assert property (fell_w && seen_reg && ph_reg == 8'h80 |-> ##12 dout_oe && dout == MASTER_IND)
      else $error("secondary top bit wrong");
endmodule // codec_serial_frame_port_asserts

// File: dv/codec_serial_frame_port_tb.sv
`timescale 1ns/10ps
module codec_serial_frame_port_tb;
   import codec_port_pkg::*;
   // *****
   // Cases
   // *****
   typedef struct packed
   {
      logic md;
      logic m;
      logic [15:0] cmd;
      logic [15:0] rep;
   } row_t;
   localparam logic MS_IND = 1'b1;
   localparam int NROW = 9;
   localparam row_t ROWS [NROW] = '{
      '{1'b0, 1'b0, 16'h2100, 16'hA100},
      '{1'b0, 1'b0, 16'h035A, 16'h8300},
      '{1'b0, 1'b0, 16'h23FF, 16'hA35A},
      '{1'b0, 1'b0, 16'h2300, 16'hA35A},
      '{1'b0, 1'b0, 16'h00FF, 16'h8000},
      '{1'b0, 1'b0, 16'h2700, 16'hA700},
      '{1'b0, 1'b0, 16'h2400, 16'hA400},
      '{1'b0, 1'b1, 16'h0101, 16'h8100},
      '{1'b1, 1'b1, 16'h2101, 16'hA101}
   };
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic mode16 = 1'b0;
   logic cmd_valid = 1'b0;
   logic [15:0] cmd_word = 16'h0000;
   logic [15:0] dac_in = 16'h8000;
   logic [15:0] adc_in = 16'h7FFE;
   logic cmd_ready;
   logic [15:0] dac_out;
   logic dac_valid;
   logic dac_mode16;
   logic [15:0] adc_out;
   logic adc_valid;
   logic [15:0] reply_word;
   logic reply_valid;
   logic prev;
   int n_fail = 0;
   int check_count = 0;
   int k;
   int n;

   always #50 sys_clk = ~sys_clk;

   codec_link_if codec_link_if_i ();

   codec_port_device #(.MASTER_IND(MS_IND)) codec_port_device_i
   (
      .SYS_CLK(sys_clk),
      .RST_N(rst_n),
      .LINK(codec_link_if_i.device),
      .ADC_WORD(adc_in),
      .DAC_WORD(dac_out),
      .DAC_VALID(dac_valid),
      .DAC_MODE16(dac_mode16)
   );

   codec_port_host codec_port_host_i
   (
      .SYS_CLK(sys_clk),
      .RST_N(rst_n),
      .LINK(codec_link_if_i.host),
      .MODE16(mode16),
      .DAC_WORD(dac_in),
      .CMD_VALID(cmd_valid),
      .CMD_WORD(cmd_word),
      .CMD_READY(cmd_ready),
      .ADC_WORD(adc_out),
      .ADC_VALID(adc_valid),
      .REPLY_WORD(reply_word),
      .REPLY_VALID(reply_valid)
   );

   codec_serial_frame_port_asserts #(.MASTER_IND(MS_IND)) codec_serial_frame_port_asserts_i
   (
      .SYS_CLK(sys_clk),
      .RST_N(rst_n),
      .sclk(codec_link_if_i.sclk),
      .fs_n(codec_link_if_i.fs_n),
      .dout(codec_link_if_i.dout),
      .dout_oe(codec_link_if_i.dout_oe),
      .din(codec_link_if_i.din)
   );

   // *****
   // Tasks
   // *****
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic tick();
      @(negedge sys_clk);
      k++;
      if (k > 12000)
      begin
         n_fail++;
         $display("BAD wait exp done seen stuck");
         report_and_stop();
      end
   endtask

   task automatic run_cmd(input logic [15:0] cmd, input logic [15:0] rep);
      k = 0;
      while (cmd_ready !== 1'b1)
         tick();
      cmd_word = cmd;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      k = 0;
      while (reply_valid !== 1'b1)
         tick();
      check("reply", reply_word, rep);
   endtask

   // Sample words move on once each primary frame has delivered
   always @(negedge sys_clk)
   begin
      if (rst_n && dac_valid === 1'b1)
      begin
         check("dac", {dac_out[15:1], 1'b0}, dac_in);
         dac_in = dac_in + 16'h1236;
      end
      if (rst_n && adc_valid === 1'b1)
      begin
         check("adc", adc_out, adc_in);
         adc_in = adc_in - 16'h0F0E;
      end
   end

   // *****
   // Sequence
   // *****
   initial
   begin
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      for (int i = 0; i < NROW; i++)
      begin
         mode16 = ROWS[i].md;
         run_cmd(ROWS[i].cmd, ROWS[i].rep);
         check("mode", 16'(dac_mode16), 16'(ROWS[i].m));
         $display("row %0d done", i);
      end
      // No command pending: primary syncs only
      n = 0;
      prev = 1'b1;
      repeat (8192)
      begin
         @(negedge sys_clk);
         if (prev === 1'b1 && codec_link_if_i.fs_n === 1'b0)
            n++;
         prev = codec_link_if_i.fs_n;
      end
      check("frames", 16'(n), 16'h0002);
      $display("idle done");
      rst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      check("sync", 16'(codec_link_if_i.fs_n), 16'h0001);
      check("oe", 16'(codec_link_if_i.dout_oe), 16'h0000);
      check("mode", 16'(dac_mode16), 16'h0000);
      check("ready", 16'(cmd_ready), 16'h0001);
      rst_n = 1'b1;
      mode16 = 1'b0;
      run_cmd(16'h2300, 16'hA300);
      $display("reset done");
      report_and_stop();
   end
endmodule // codec_serial_frame_port_tb
